// >>> src/sp_cfg.svh
// Serial port constants: register map, field positions, reset values
// Assumes inclusion by the design file and the bench top only
`ifndef SP_CFG_SVH
`define SP_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SP_ADDR_W      2
`define SP_ADDR_CTRL   2'h0
`define SP_ADDR_BUF    2'h1
`define SP_ADDR_PWR    2'h2

// ----------------------------------------
// Control and power register fields, reset byte
// ----------------------------------------
`define SP_CTRL_MODE_HI 7
`define SP_CTRL_MODE_LO 6
`define SP_CTRL_MP      5
`define SP_CTRL_REN     4
`define SP_CTRL_TB8     3
`define SP_CTRL_RB8     2
`define SP_CTRL_TXDONE  1
`define SP_CTRL_RXDONE  0
`define SP_PWR_DOUBLE   7
`define SP_RST_BYTE     8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SP_M0_HALF      6
`define SP_DIV_LAST     4'hf
`define SP_VOTE_S1      4'h7
`define SP_VOTE_S2      4'h8
`define SP_VOTE_S3      4'h9
`define SP_BITS_8       4'ha
`define SP_BITS_9       4'hb
`define SP_M0_LAST      3'h7

`endif

// >>> src/sp_pkg.sv
// Serial port types
// Assumes compilation before the modules that import it
package sp_pkg;
	typedef enum logic [1:0] {
		sp_mode_shift,
		sp_mode_uart8,
		sp_mode_uart9,
		sp_mode_uart9t
	} sp_mode_t;
endpackage

// >>> src/sp_serial.sv
// Serial port: shift-register mode and 10/11-bit asynchronous modes
// Assumes a register master on core_clk and a one-cycle timer-1
// overflow pulse from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "sp_cfg.svh"

module sp_serial
	import sp_pkg::*;
#(
	parameter int M0_HALF = `SP_M0_HALF
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic [`SP_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  t1_ovf,
	input  wire logic                  rxd_in,
	output logic                       rxd_out,
	output logic                       rxd_oe_n,
	output logic                       txd_out,
	output logic                       serial_irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	sp_mode_t    mode_ff;
	logic        mp_ff;
	logic        rx_en_ff;
	logic        tb8_ff;
	logic        rx_ninth_bit_ff;
	logic        tx_done_flag_ff;
	logic        rx_done_flag_ff;
	logic        baud_double_bit_ff;
	logic [7:0]  rx_buf_ff;
	logic [7:0]  rdata_ff;

	logic        wr_ctrl;
	logic        wr_buf;
	logic        wr_pwr;
	logic        async_mode;
	logic        nine_bit;

	assign wr_ctrl    = reg_wr && (reg_addr == `SP_ADDR_CTRL);
	assign wr_buf     = reg_wr && (reg_addr == `SP_ADDR_BUF);
	assign wr_pwr     = reg_wr && (reg_addr == `SP_ADDR_PWR);
	assign async_mode = (mode_ff != sp_mode_shift);
	assign nine_bit   = (mode_ff == sp_mode_uart9) ||
		(mode_ff == sp_mode_uart9t);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic rxd_s1_ff;
	logic rxd_s2_ff;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxd_s1_ff <= 1'b1;
			rxd_s2_ff <= 1'b1;
		end else begin
			rxd_s1_ff <= rxd_in;
			rxd_s2_ff <= rxd_s1_ff;
		end
	end

	// ----------------------------------------
	// Sixteen-times bit rate tick
	// ----------------------------------------
	logic [1:0] pre_ff;
	logic       t1_half_ff;
	logic       tick;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pre_ff     <= 2'h0;
			t1_half_ff <= 1'b0;
		end else begin
			pre_ff <= pre_ff + 2'h1;
			if (t1_ovf)
				t1_half_ff <= ~t1_half_ff;
		end
	end

	// sp_mode_uart9: oscillator /2 or /4 gives bit /32 or /64; other modes use timer-1 overflows
	always_comb begin
		if (mode_ff == sp_mode_uart9)
			tick = baud_double_bit_ff ? pre_ff[0] : (pre_ff == 2'h3);
		else
			tick = t1_ovf && (baud_double_bit_ff || t1_half_ff);
	end

	// ----------------------------------------
	// Asynchronous transmitter
	// ----------------------------------------
	logic [3:0]  tx_div_ff;
	logic        tx_roll;
	logic        tx_busy_ff;
	logic [3:0]  tx_cnt_ff;
	logic [10:0] tx_sh_ff;
	logic        tx_line_ff;
	logic        tx_last;
	logic        async_tx_done;

	assign tx_roll = tick && (tx_div_ff == `SP_DIV_LAST);
	assign tx_last = (tx_cnt_ff + 4'h1) ==
		(nine_bit ? `SP_BITS_9 : `SP_BITS_8);
	assign async_tx_done = tx_busy_ff && tx_roll && tx_last;

	always_ff @(posedge core_clk) begin
		if (srst)
			tx_div_ff <= 4'h0;
		else if (tick)
			tx_div_ff <= tx_div_ff + 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_busy_ff <= 1'b0;
			tx_cnt_ff  <= 4'h0;
			tx_sh_ff   <= 11'h7ff;
			tx_line_ff <= 1'b1;
		end else if (!tx_busy_ff) begin
			if (wr_buf && async_mode) begin
				tx_busy_ff <= 1'b1;
				tx_cnt_ff  <= 4'h0;
				// Start low, data LSB first, ninth, stop high
				tx_sh_ff <= {1'b1, nine_bit ? tb8_ff : 1'b1,
					reg_wdata, 1'b0};
			end
		end else if (tx_roll) begin
			tx_line_ff <= tx_sh_ff[0];
			tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
			tx_cnt_ff  <= tx_cnt_ff + 4'h1;
			if (tx_last)
				tx_busy_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Asynchronous receiver
	// ----------------------------------------
	logic [3:0] rx_div_ff;
	logic       rx_busy_ff;
	logic [3:0] rx_idx_ff;
	logic [1:0] rx_smp_ff;
	logic       rx_prev_ff;
	logic [8:0] rx_sh_ff;
	logic       rx_fall;
	logic       rx_vote_pt;
	logic       vote;
	logic       rx_final;
	logic       rx_accept;

	assign rx_fall = tick && !rx_busy_ff && rx_en_ff && async_mode &&
		rx_prev_ff && !rxd_s2_ff;
	assign rx_vote_pt = rx_busy_ff && tick && (rx_div_ff == `SP_VOTE_S3);
	assign vote = (rx_smp_ff[1] & rx_smp_ff[0]) |
		(rx_smp_ff[1] & rxd_s2_ff) | (rx_smp_ff[0] & rxd_s2_ff);
	assign rx_final = rx_vote_pt && ((rx_idx_ff + 4'h1) ==
		(nine_bit ? `SP_BITS_9 : `SP_BITS_8));
	assign rx_accept = rx_final && !rx_done_flag_ff &&
		(!mp_ff || vote);

	always_ff @(posedge core_clk) begin
		if (srst)
			rx_prev_ff <= 1'b1;
		else if (tick)
			rx_prev_ff <= rxd_s2_ff;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			rx_div_ff <= 4'h0;
		else if (rx_fall)
			rx_div_ff <= 4'h0;
		else if (tick)
			rx_div_ff <= rx_div_ff + 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_smp_ff <= 2'h0;
		end else if (rx_busy_ff && tick) begin
			if (rx_div_ff == `SP_VOTE_S1)
				rx_smp_ff[1] <= rxd_s2_ff;
			if (rx_div_ff == `SP_VOTE_S2)
				rx_smp_ff[0] <= rxd_s2_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_busy_ff <= 1'b0;
			rx_idx_ff  <= 4'h0;
			rx_sh_ff   <= 9'h000;
		end else if (rx_fall) begin
			rx_busy_ff <= 1'b1;
			rx_idx_ff  <= 4'h0;
		end else if (rx_vote_pt) begin
			rx_idx_ff <= rx_idx_ff + 4'h1;
			if (rx_idx_ff == 4'h0 && vote)
				rx_busy_ff <= 1'b0;
			else if (rx_final)
				rx_busy_ff <= 1'b0;
			else if (rx_idx_ff != 4'h0)
				rx_sh_ff <= {vote, rx_sh_ff[8:1]};
		end
	end

	// ----------------------------------------
	// Shift-register mode engine
	// ----------------------------------------
	logic       m0_busy_ff;
	logic       m0_rx_ff;
	logic [7:0] m0_ph_ff;
	logic       m0_clk_ff;
	logic [2:0] m0_cnt_ff;
	logic [7:0] m0_sh_ff;
	logic       m0_edge;
	logic       m0_done;

	assign m0_edge = m0_busy_ff && (m0_ph_ff == 8'(M0_HALF - 1));
	assign m0_done = m0_edge && m0_clk_ff && (m0_cnt_ff == `SP_M0_LAST);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			m0_busy_ff <= 1'b0;
			m0_rx_ff   <= 1'b0;
			m0_ph_ff   <= 8'h00;
			m0_clk_ff  <= 1'b1;
			m0_cnt_ff  <= 3'h0;
			m0_sh_ff   <= 8'h00;
		end else if (!m0_busy_ff) begin
			m0_ph_ff <= 8'h00;
			if (mode_ff == sp_mode_shift) begin
				if (wr_buf) begin
					m0_busy_ff <= 1'b1;
					m0_rx_ff   <= 1'b0;
					m0_cnt_ff  <= 3'h0;
					m0_sh_ff   <= reg_wdata;
					m0_clk_ff  <= 1'b0;
				end else if (rx_en_ff && !rx_done_flag_ff) begin
					m0_busy_ff <= 1'b1;
					m0_rx_ff   <= 1'b1;
					m0_cnt_ff  <= 3'h0;
					m0_clk_ff  <= 1'b0;
				end
			end
		end else if (!m0_edge) begin
			m0_ph_ff <= m0_ph_ff + 8'h01;
		end else begin
			m0_ph_ff <= 8'h00;
			if (!m0_clk_ff) begin
				m0_clk_ff <= 1'b1;
				if (m0_rx_ff)
					m0_sh_ff <= {rxd_s2_ff, m0_sh_ff[7:1]};
			end else if (m0_done) begin
				m0_busy_ff <= 1'b0;
			end else begin
				// Falling edge: next bit, partner shifts too
				m0_clk_ff <= 1'b0;
				m0_cnt_ff <= m0_cnt_ff + 3'h1;
				if (!m0_rx_ff)
					m0_sh_ff <= {1'b0, m0_sh_ff[7:1]};
			end
		end
	end

	// ----------------------------------------
	// Receive buffer and ninth bit
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst)
			rx_buf_ff <= `SP_RST_BYTE;
		else if (m0_done && m0_rx_ff)
			rx_buf_ff <= m0_sh_ff;
		else if (rx_accept)
			rx_buf_ff <= nine_bit ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			rx_ninth_bit_ff <= 1'b0;
		else if (rx_accept)
			rx_ninth_bit_ff <= nine_bit ? rx_sh_ff[8] : vote;
		else if (wr_ctrl)
			rx_ninth_bit_ff <= reg_wdata[`SP_CTRL_RB8];
	end

	// ----------------------------------------
	// Done flags: hardware set beats software clear
	// ----------------------------------------
	logic set_tx_done;
	logic set_rx_done;

	assign set_tx_done = async_tx_done || (m0_done && !m0_rx_ff);
	assign set_rx_done = rx_accept || (m0_done && m0_rx_ff);

	always_ff @(posedge core_clk) begin
		if (srst)
			tx_done_flag_ff <= 1'b0;
		else if (set_tx_done)
			tx_done_flag_ff <= 1'b1;
		else if (wr_ctrl)
			tx_done_flag_ff <= reg_wdata[`SP_CTRL_TXDONE];
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			rx_done_flag_ff <= 1'b0;
		else if (set_rx_done)
			rx_done_flag_ff <= 1'b1;
		else if (wr_ctrl)
			rx_done_flag_ff <= reg_wdata[`SP_CTRL_RXDONE];
	end

	// ----------------------------------------
	// Control and power registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_ff  <= sp_mode_shift;
			mp_ff    <= 1'b0;
			rx_en_ff <= 1'b0;
			tb8_ff   <= 1'b0;
		end else if (wr_ctrl) begin
			mode_ff  <= sp_mode_t'(reg_wdata[`SP_CTRL_MODE_HI:
				`SP_CTRL_MODE_LO]);
			mp_ff    <= reg_wdata[`SP_CTRL_MP];
			rx_en_ff <= reg_wdata[`SP_CTRL_REN];
			tb8_ff   <= reg_wdata[`SP_CTRL_TB8];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			baud_double_bit_ff <= 1'b0;
		else if (wr_pwr)
			baud_double_bit_ff <= reg_wdata[`SP_PWR_DOUBLE];
	end

	// ----------------------------------------
	// Read port, data one cycle after strobe
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SP_ADDR_CTRL: rdata_ff <= {mode_ff, mp_ff, rx_en_ff,
					tb8_ff, rx_ninth_bit_ff, tx_done_flag_ff,
					rx_done_flag_ff};
				`SP_ADDR_BUF: rdata_ff <= rx_buf_ff;
				`SP_ADDR_PWR: rdata_ff <= {baud_double_bit_ff, 7'h00};
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata  = rdata_ff;
	// Shift mode puts its clock on the transmit pin
	assign txd_out    = (mode_ff == sp_mode_shift) ? m0_clk_ff : tx_line_ff;
	assign rxd_out    = m0_sh_ff[0];
	assign rxd_oe_n   = !(m0_busy_ff && !m0_rx_ff);
	assign serial_irq = tx_done_flag_ff || rx_done_flag_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [3:0] chk_roll_ff;

	always_ff @(posedge core_clk) begin
		if (srst || (wr_buf && !tx_busy_ff))
			chk_roll_ff <= 4'h0;
		else if (tx_roll && tx_busy_ff)
			chk_roll_ff <= chk_roll_ff + 4'h1;
	end

	a_irq_flags: assert property (@(posedge core_clk) disable iff (srst)
		set_tx_done || set_rx_done |=> serial_irq)
		else $error("irq missing after flag set");
	a_m0_rx_gate: assert property (@(posedge core_clk) disable iff (srst)
		$rose(m0_busy_ff) && m0_rx_ff |-> $past(rx_en_ff && !rx_done_flag_ff))
		else $error("shift receive started while blocked");
	a_m0_halt: assert property (@(posedge core_clk) disable iff (srst)
		m0_done && m0_rx_ff |=> rx_done_flag_ff && !m0_busy_ff)
		else $error("shift receive did not halt");
	a_m0_tx_flag: assert property (@(posedge core_clk) disable iff (srst)
		$rose(tx_done_flag_ff) && mode_ff == sp_mode_shift &&
		!$past(wr_ctrl) && !$past(tx_busy_ff) |->
		$past(m0_clk_ff) && $past(m0_cnt_ff) == 3'h7)
		else $error("shift transmit flag early");
	a_tx_on_roll: assert property (@(posedge core_clk) disable iff (srst)
		$changed(tx_line_ff) |-> $past(tx_roll))
		else $error("tx pin changed off rollover");
	a_tx_done_cnt: assert property (@(posedge core_clk)
		disable iff (srst)
		$past(async_tx_done) |->
		chk_roll_ff == (nine_bit ? `SP_BITS_9 : `SP_BITS_8))
		else $error("tx flag at wrong rollover");
	a_rx_edge_rst: assert property (@(posedge core_clk)
		disable iff (srst)
		rx_fall |=> rx_div_ff == 4'h0 && rx_busy_ff)
		else $error("edge did not reset counter");
	a_rx_abort: assert property (@(posedge core_clk) disable iff (srst)
		rx_vote_pt && rx_idx_ff == 4'h0 && vote |=> !rx_busy_ff)
		else $error("bad start not aborted");
	a_rx_start_en: assert property (@(posedge core_clk)
		disable iff (srst)
		$rose(rx_busy_ff) |-> $past(rx_en_ff) && !$past(rxd_s2_ff))
		else $error("receive started without enable");
	a_rx_load: assert property (@(posedge core_clk) disable iff (srst)
		$rose(rx_done_flag_ff) && async_mode && !$past(wr_ctrl) |->
		!$past(rx_done_flag_ff) && ($past(!mp_ff) || $past(vote)))
		else $error("receive load without condition");

	c_m0_rx: cover property (@(posedge core_clk) m0_done && m0_rx_ff);
	c_tx_frame: cover property (@(posedge core_clk) async_tx_done);
	c_rx_frame: cover property (@(posedge core_clk) rx_accept);
	c_rx_abort: cover property (@(posedge core_clk)
		rx_vote_pt && rx_idx_ff == 4'h0 && vote);

endmodule // sp_serial

`default_nettype wire

// >>> tb/sp_far_end.sv
// Far-end model: async line partner and shift-mode peripheral
// Assumes the block's core clock and direct sight of its pins
`timescale 1ns/1ps
`default_nettype none
module sp_far_end (
	input  wire logic core_clk,
	input  wire logic txd_out,
	input  wire logic rxd_out,
	input  wire logic rxd_oe_n,
	output logic      rxd_in
);
	logic       line_ff = 1'b1;
	logic       sh_mode = 1'b0;
	logic       sh_bit  = 1'b1;
	logic       txd_ff  = 1'b1;
	logic [7:0] sh_tx   = 8'h00;
	logic [7:0] sh_cap  = 8'h00;

	// Device drive wins, else peripheral or idle-high line
	assign rxd_in = !rxd_oe_n ? rxd_out : (sh_mode ? sh_bit : line_ff);

	always @(posedge core_clk) begin
		txd_ff <= txd_out;
		// Inverse shifted in so a stale bit never repeats
		if (sh_mode && txd_ff && !txd_out) begin
			sh_bit <= sh_tx[0];
			sh_tx  <= {~sh_tx[0], sh_tx[7:1]};
		end
		if (sh_mode && !txd_ff && txd_out && !rxd_oe_n)
			sh_cap <= {rxd_out, sh_cap[7:1]};
	end

	task automatic send(input logic [10:0] f, input int nb, input int bclk);
		for (int i = 0; i < nb; i++) begin
			line_ff <= f[i];
			repeat (bclk) @(posedge core_clk);
		end
	endtask

	// Mid-bit sampling after the start edge
	task automatic recv(output logic [10:0] f, input int nb, input int bclk);
		f = 11'h7ff;
		while (txd_out !== 1'b0)
			@(posedge core_clk);
		repeat (bclk / 2) @(posedge core_clk);
		for (int i = 0; i < nb; i++) begin
			f[i] = txd_out;
			repeat (bclk) @(posedge core_clk);
		end
	endtask
endmodule // sp_far_end
`default_nettype wire

// >>> tb/sp_serial_tb_top.sv
// Serial port bench: frame table, then hand-written cases
// Assumes sp_far_end on the pins and t1_ovf every second clock
`timescale 1ns/1ps
`default_nettype none
`include "sp_cfg.svh"
module sp_serial_tb_top
	import sp_pkg::*;
;
	typedef struct packed {
		sp_mode_t   mode;
		logic       dbl;
		logic [7:0] data;
		logic       tb8;
		logic [6:0] bclk;
	} sp_row_t;

	logic                  core_clk, srst, reg_wr, reg_rd, t1_ovf;
	logic                  rxd_in, rxd_out, rxd_oe_n, txd_out, serial_irq;
	logic [`SP_ADDR_W-1:0] reg_addr;
	logic [7:0]            reg_wdata, reg_rdata, v;
	logic [10:0]           f, g;
	int                    n_errors, checks, cyc, nb;
	sp_row_t               rows [5];

	sp_serial #(.M0_HALF(6)) u_sp_serial (.core_clk, .srst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .t1_ovf, .rxd_in,
		.rxd_out, .rxd_oe_n, .txd_out, .serial_irq);
	sp_far_end u_sp_far_end (.core_clk, .txd_out, .rxd_out, .rxd_oe_n,
		.rxd_in);

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk_reg(input logic [1:0] a, input logic [7:0] e,
		input string nm);
		rd(a, v);
		chk(nm, e, v);
	endtask

	task automatic end_sim();
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Nine-bit frame with chosen stop; line back to idle high after it
	task automatic frame(input logic sb, input logic n9, input logic [7:0] d);
		f = {sb, n9, d, 1'b0};
		u_sp_far_end.send(f, 11, 32);
		u_sp_far_end.line_ff <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Hang guard: roughly four times the expected run
	always @(posedge core_clk) begin
		cyc    <= cyc + 1;
		t1_ovf <= srst ? 1'b0 : ~t1_ovf;
		if (cyc == 30000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		srst      = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 2'h0;
		reg_wdata = 8'h00;
		rows[0]   = '{sp_mode_uart8, 1'b1, 8'ha5, 1'b0, 7'h20};
		rows[1]   = '{sp_mode_uart9, 1'b1, 8'h3c, 1'b1, 7'h20};
		rows[2]   = '{sp_mode_uart9, 1'b0, 8'hc3, 1'b0, 7'h40};
		rows[3]   = '{sp_mode_uart9t, 1'b1, 8'h5a, 1'b1, 7'h20};
		rows[4]   = '{sp_mode_uart8, 1'b0, 8'h0f, 1'b1, 7'h40};
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		chk_reg(`SP_ADDR_CTRL, 8'h00, "ctrl_reset");
		chk_reg(`SP_ADDR_PWR, 8'h00, "pwr_reset");
		chk("idle_pins", 8'h03, {6'h00, txd_out, rxd_oe_n});
		chk("irq_reset", 8'h00, {7'h00, serial_irq});
		foreach (rows[i]) begin
			nb = (rows[i].mode == sp_mode_uart8) ? 10 : 11;
			f = {1'b1, (nb == 10) | rows[i].tb8, rows[i].data, 1'b0};
			wr(`SP_ADDR_PWR, {rows[i].dbl, 7'h00});
			wr(`SP_ADDR_CTRL, {rows[i].mode, 2'b01, rows[i].tb8, 3'b000});
			wr(`SP_ADDR_BUF, rows[i].data);
			u_sp_far_end.recv(g, nb, rows[i].bclk);
			chk("tx_data", f[8:1], g[8:1]);
			chk("tx_frame", {5'h00, f[0], f[9], 1'b1},
				{5'h00, g[0], g[9], g[nb-1]});
			chk_reg(`SP_ADDR_CTRL, {rows[i].mode, 2'b01, rows[i].tb8, 3'b010},
				"tx_ctrl");
			chk("irq_tx", 8'h01, {7'h00, serial_irq});
			// Flags stay set until software writes them clear
			wr(`SP_ADDR_CTRL, {rows[i].mode, 2'b01, rows[i].tb8, 3'b000});
			u_sp_far_end.send(f, nb, rows[i].bclk);
			repeat (4) @(posedge core_clk);
			chk_reg(`SP_ADDR_BUF, rows[i].data,
				"rx_data");
			chk_reg(`SP_ADDR_CTRL, {rows[i].mode, 2'b01, rows[i].tb8, f[9], 2'b01},
				"rx_ctrl");
		end
		wr(`SP_ADDR_PWR, 8'h80);
		wr(`SP_ADDR_CTRL, 8'h90);
		// Low glitch of three ticks: start vote must read high
		u_sp_far_end.line_ff <= 1'b0;
		repeat (6) @(posedge core_clk);
		u_sp_far_end.line_ff <= 1'b1;
		repeat (400) @(posedge core_clk);
		chk_reg(`SP_ADDR_CTRL, 8'h90, "bad_start");
		frame(1'b1, 1'b1, 8'h3c);
		chk_reg(`SP_ADDR_BUF, 8'h3c, "after_abort");
		wr(`SP_ADDR_CTRL, 8'hb0);
		// Filter on, stop bit low: frame must be dropped
		frame(1'b0, 1'b1, 8'h5a);
		chk_reg(`SP_ADDR_CTRL, 8'hb0, "filter_ctrl");
		chk_reg(`SP_ADDR_BUF, 8'h3c, "filter_data");
		frame(1'b1, 1'b1, 8'ha5);
		chk_reg(`SP_ADDR_CTRL, 8'hb5, "filter_pass");
		frame(1'b1, 1'b1, 8'h0f);
		chk_reg(`SP_ADDR_BUF, 8'ha5, "flag_held");
		wr(`SP_ADDR_CTRL, 8'h80);
		frame(1'b1, 1'b1, 8'h77);
		chk_reg(`SP_ADDR_CTRL, 8'h80, "rx_off");
		wr(2'h3, 8'hff);
		chk_reg(2'h3, 8'h00, "unmapped");
		u_sp_far_end.sh_tx   <= 8'h96;
		u_sp_far_end.sh_mode <= 1'b1;
		wr(`SP_ADDR_CTRL, 8'h10);
		for (int k = 0; k < 100 && v[0] !== 1'b1; k++)
			rd(`SP_ADDR_CTRL, v);
		chk("m0_rx_ctrl", 8'h11, v);
		chk_reg(`SP_ADDR_BUF, 8'h96, "m0_rx_data");
		repeat (200) @(posedge core_clk);
		chk_reg(`SP_ADDR_BUF, 8'h96, "m0_halt");
		chk("m0_clk_idle", 8'h01, {7'h00, txd_out});
		wr(`SP_ADDR_CTRL, 8'h00);
		wr(`SP_ADDR_BUF, 8'h6b);
		v = 8'h00;
		for (int k = 0; k < 100 && v[1] !== 1'b1; k++)
			rd(`SP_ADDR_CTRL, v);
		chk("m0_tx_ctrl", 8'h02, v);
		chk("m0_tx_data", 8'h6b, u_sp_far_end.sh_cap);
		end_sim();
	end
endmodule // sp_serial_tb_top
`default_nettype wire
